// ===== hdl/port_ctrl_regs.svh
/*
 Register indices, field positions, reset values and pin layout of the port block.
 Assumes a 32-bit register bus where byte address equals four times the index.
*/
`ifndef PORT_CTRL_REGS_SVH
`define PORT_CTRL_REGS_SVH
`define IDX_PORT_A_DATA 6'h00
`define IDX_PORT_A_DIR 6'h01
`define IDX_PORT_B_DIR 6'h02
`define IDX_PORT_B_DATA 6'h04
`define IDX_PORT_C_DATA 6'h06
`define IDX_PORT_C_DIR 6'h07
`define IDX_PORT_D_DATA 6'h08
`define IDX_PORT_D_DIR 6'h09
`define IDX_SPI_CTRL 6'h28
`define IDX_SCI_CTRL_ONE 6'h2C
`define IDX_OPTIONS_TWO 6'h38
`define IDX_PULLUP_SEL 6'h3D
`define BIT_DATABUS_OD 6
`define BIT_SPI_ON 6
`define BIT_SPI_PINS_OD 5
`define BIT_SPI_MASTER 4
`define BIT_SCI_PINS_OD 6
`define BIT_PULLUP_B 0
`define BIT_PULLUP_C 1
`define MASK_OPTIONS_TWO 8'hDF
`define MASK_SCI_CTRL_ONE 8'hDF
`define MASK_PORT_D 8'h3F
`define MASK_PULLUP_SEL 8'h03
`define RST_BYTE 8'h00
`define ALL_ONES 8'hFF
`define SPI_MASTER_OUTS 3'h6
`define SPI_SLAVE_OUTS 3'h1
`define PIN_A 0
`define PIN_B 8
`define PIN_C 16
`define PIN_D 24
`define PIN_COUNT 30
`endif

// ===== hdl/port_ctrl_pkg.sv
/*
 Shared types of the port block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package port_ctrl_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [5:0] reg_index_t;
   typedef enum logic [1:0] {
      RESP_OKAY = 2'h0,
      RESP_DECERR = 2'h3
   } axi_resp_t;
endpackage

// ===== hdl/reg_access_if.sv
/*
 Internal register access path between the bus slave and the register file.
 Assumes both sides run on the same clock.
*/
`timescale 1ns/10ps
interface reg_access_if;
   logic wrEn;
   port_ctrl_pkg::reg_index_t wrIndex;
   port_ctrl_pkg::byte_t wrData;
   logic wrHit;
   port_ctrl_pkg::reg_index_t rdIndex;
   port_ctrl_pkg::byte_t rdData;
   logic rdHit;
   modport bus (output wrEn, output wrIndex, output wrData, output rdIndex,
      input wrHit, input rdData, input rdHit);
   modport regs (input wrEn, input wrIndex, input wrData, input rdIndex,
      output wrHit, output rdData, output rdHit);
endinterface

// ===== hdl/axil_reg_slave.sv
/*
 AXI4-Lite slave that turns bus accesses into register accesses.
 Assumes 8-bit addresses, one aligned word per register, data in the low byte.
*/
`timescale 1ns/10ps
module axil_reg_slave (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Write channels.
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // Read channels.
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Register side.
   reg_access_if.bus acc
);
   logic awHave_q, wHave_q, wStrb_q, bValid_q, rValid_q;
   port_ctrl_pkg::reg_index_t awIdx_q;
   port_ctrl_pkg::byte_t wData_q, rData_q;
   port_ctrl_pkg::axi_resp_t bResp_q, rResp_q;
   wire logic awTake, wTake, arTake, doWrite;

   // Address and data are held until both are present; a pending answer blocks new ones.
   assign awready = ~awHave_q & ~bValid_q;
   assign wready = ~wHave_q & ~bValid_q;
   assign arready = ~rValid_q;
   assign awTake = awvalid & awready;
   assign wTake = wvalid & wready;
   assign arTake = arvalid & arready;
   assign doWrite = awHave_q & wHave_q & ~bValid_q;
   assign acc.wrEn = doWrite & wStrb_q;
   assign acc.wrIndex = awIdx_q;
   assign acc.wrData = wData_q;
   assign acc.rdIndex = araddr[7:2];
   assign bvalid = bValid_q;
   assign bresp = bResp_q;
   assign rvalid = rValid_q;
   assign rresp = rResp_q;
   assign rdata = {24'h000000, rData_q};

   // Write path: capture, perform, answer.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         awIdx_q <= 6'h00;
         wData_q <= 8'h00;
         wStrb_q <= 1'b0;
         bValid_q <= 1'b0;
         bResp_q <= port_ctrl_pkg::RESP_OKAY;
      end else begin
         awHave_q <= doWrite ? 1'b0 : (awHave_q | awTake);
         wHave_q <= doWrite ? 1'b0 : (wHave_q | wTake);
         if (awTake) awIdx_q <= awaddr[7:2];
         if (wTake) wData_q <= wdata[7:0];
         if (wTake) wStrb_q <= wstrb[0];
         if (doWrite) bResp_q <= acc.wrHit ? port_ctrl_pkg::RESP_OKAY : port_ctrl_pkg::RESP_DECERR;
         bValid_q <= doWrite | (bValid_q & ~bready);
      end
   end

   // Read path: data sampled on the address handshake, held until taken.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rValid_q <= 1'b0;
         rData_q <= 8'h00;
         rResp_q <= port_ctrl_pkg::RESP_OKAY;
      end else begin
         if (arTake) rData_q <= acc.rdHit ? acc.rdData : 8'h00;
         if (arTake) rResp_q <= acc.rdHit ? port_ctrl_pkg::RESP_OKAY : port_ctrl_pkg::RESP_DECERR;
         rValid_q <= arTake | (rValid_q & ~rready);
      end
   end
endmodule // axil_reg_slave

// ===== hdl/pin_output_stage.sv
/*
 Registered output stage for all port pins, with open-drain conversion per pin.
 Assumes the pad resolves the level from the output and its enable.
*/
`timescale 1ns/10ps
`include "port_ctrl_regs.svh"
module pin_output_stage (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Requested drive per pin.
   input wire logic [`PIN_COUNT-1:0] want,
   input wire logic [`PIN_COUNT-1:0] value,
   input wire logic [`PIN_COUNT-1:0] openDrain,
   // Pad side.
   output logic [`PIN_COUNT-1:0] pinOut,
   output logic [`PIN_COUNT-1:0] pinOe
);
   logic [`PIN_COUNT-1:0] oe_d, out_d;

   // An open-drain pin only pulls low and releases for a one.
   for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_pin
      assign oe_d[i] = want[i] & ~(openDrain[i] & value[i]);
      assign out_d[i] = value[i] & ~openDrain[i];
   end

   // Pads start released.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pinOe <= '0;
         pinOut <= '0;
      end else begin
         pinOe <= oe_d;
         pinOut <= out_d;
      end
   end
endmodule // pin_output_stage

// ===== hdl/parallel_port_direction_control.sv
/*
 Parallel port register file and pin direction logic for ports A to D.
 Assumes an AXI4-Lite master, an external bus controller in expanded mode, and
 SPI and SCI engines that supply pin values and use the control registers exported here.
*/
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "port_ctrl_regs.svh"

module parallel_port_direction_control (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // AXI4-Lite write channels.
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read channels.
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Operating mode, high in expanded or test mode.
   input wire logic modeExpanded,
   // External bus controller.
   input wire logic [7:0] extAddrHigh,
   input wire logic [7:0] extDataOut,
   input wire logic extDataDrive,
   output logic [7:0] extDataIn,
   // Serial engines.
   input wire logic [2:0] spiPinOut,
   input wire logic sciTxEnable,
   input wire logic sciTxData,
   input wire logic sciRxEnable,
   output logic [7:0] serialPeripheralControl,
   output logic [7:0] asyncSerialControlOne,
   output logic [7:0] systemOptionsTwo,
   // Pads: A bits 7..0, B 15..8, C 23..16, D 29..24.
   input wire logic [29:0] pinIn,
   output logic [29:0] pinOut,
   output logic [29:0] pinOe,
   output logic [15:0] pullUpEnable
);
   // Register access path shared with the bus slave.
   reg_access_if acc ();

   port_ctrl_pkg::byte_t dataA_q, dirA_q, dataB_q, dirB_q, dataC_q, dirC_q;
   port_ctrl_pkg::byte_t dataD_q, dirD_q, spiCtrl_q, sciCtrl_q, optTwo_q, pullSel_q;
   port_ctrl_pkg::byte_t inA, inB, inC, inD, readA, readB, readC, readD;
   logic [7:0] wantB, valB, wantC, valC;
   logic [5:0] wantD, valD;
   logic [`PIN_COUNT-1:0] wantAll, valAll, odAll;
   wire logic wrA, wrDirA, wrB, wrDirB, wrC, wrDirC, wrD, wrDirD;
   wire logic wrSpi, wrSci, wrOpt, wrPull, rdHitRaw, wrHitRaw, busPortIdxRd, busPortIdxWr;
   wire logic spiOn, spiMaster, spiPinsOd, sciPinsOd, databusOd;
   wire logic [2:0] spiOuts;

   // Bus slave that turns AXI4-Lite accesses into register accesses.
   axil_reg_slave u_slave (
      .clock(clock), .rst(rst),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .acc(acc.bus)
   );

   // Index is inside the register map.
   function automatic logic knownIndex(input port_ctrl_pkg::reg_index_t idx);
      knownIndex = (idx == `IDX_PORT_A_DATA) || (idx == `IDX_PORT_A_DIR) ||
         (idx == `IDX_PORT_B_DIR) || (idx == `IDX_PORT_B_DATA) ||
         (idx == `IDX_PORT_C_DATA) || (idx == `IDX_PORT_C_DIR) ||
         (idx == `IDX_PORT_D_DATA) || (idx == `IDX_PORT_D_DIR) ||
         (idx == `IDX_SPI_CTRL) || (idx == `IDX_SCI_CTRL_ONE) ||
         (idx == `IDX_OPTIONS_TWO) || (idx == `IDX_PULLUP_SEL);
   endfunction

   // In expanded mode the address and data port latches leave the map.
   assign busPortIdxRd = (acc.rdIndex == `IDX_PORT_B_DATA) || (acc.rdIndex == `IDX_PORT_C_DATA);
   assign busPortIdxWr = (acc.wrIndex == `IDX_PORT_B_DATA) || (acc.wrIndex == `IDX_PORT_C_DATA);
   assign rdHitRaw = knownIndex(acc.rdIndex);
   assign wrHitRaw = knownIndex(acc.wrIndex);
   assign acc.rdHit = rdHitRaw & ~(modeExpanded & busPortIdxRd);
   assign acc.wrHit = wrHitRaw & ~(modeExpanded & busPortIdxWr);

   // Write strobes per register.
   assign wrA = acc.wrEn && acc.wrIndex == `IDX_PORT_A_DATA;
   assign wrDirA = acc.wrEn && acc.wrIndex == `IDX_PORT_A_DIR;
   assign wrB = acc.wrEn && acc.wrHit && acc.wrIndex == `IDX_PORT_B_DATA;
   assign wrDirB = acc.wrEn && acc.wrIndex == `IDX_PORT_B_DIR;
   assign wrC = acc.wrEn && acc.wrHit && acc.wrIndex == `IDX_PORT_C_DATA;
   assign wrDirC = acc.wrEn && acc.wrIndex == `IDX_PORT_C_DIR;
   assign wrD = acc.wrEn && acc.wrIndex == `IDX_PORT_D_DATA;
   assign wrDirD = acc.wrEn && acc.wrIndex == `IDX_PORT_D_DIR;
   assign wrSpi = acc.wrEn && acc.wrIndex == `IDX_SPI_CTRL;
   assign wrSci = acc.wrEn && acc.wrIndex == `IDX_SCI_CTRL_ONE;
   assign wrOpt = acc.wrEn && acc.wrIndex == `IDX_OPTIONS_TWO;
   assign wrPull = acc.wrEn && acc.wrIndex == `IDX_PULLUP_SEL;

   // Port output latches; a write updates the latch whatever the direction.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dataA_q <= `RST_BYTE;
         dataB_q <= `RST_BYTE;
         dataC_q <= `RST_BYTE;
         dataD_q <= `RST_BYTE;
      end else begin
         if (wrA) dataA_q <= acc.wrData;
         if (wrB) dataB_q <= acc.wrData;
         if (wrC) dataC_q <= acc.wrData;
         if (wrD) dataD_q <= acc.wrData & `MASK_PORT_D;
      end
   end

   // Direction registers, all inputs after reset.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dirA_q <= `RST_BYTE;
         dirB_q <= `RST_BYTE;
         dirC_q <= `RST_BYTE;
         dirD_q <= `RST_BYTE;
      end else begin
         if (wrDirA) dirA_q <= acc.wrData;
         if (wrDirB) dirB_q <= acc.wrData;
         if (wrDirC) dirC_q <= acc.wrData;
         if (wrDirD) dirD_q <= acc.wrData & `MASK_PORT_D;
      end
   end

   // Control registers; unimplemented bits stay zero.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         spiCtrl_q <= `RST_BYTE;
         sciCtrl_q <= `RST_BYTE;
         optTwo_q <= `RST_BYTE;
         pullSel_q <= `RST_BYTE;
      end else begin
         if (wrSpi) spiCtrl_q <= acc.wrData;
         if (wrSci) sciCtrl_q <= acc.wrData & `MASK_SCI_CTRL_ONE;
         if (wrOpt) optTwo_q <= acc.wrData & `MASK_OPTIONS_TWO;
         if (wrPull) pullSel_q <= acc.wrData & `MASK_PULLUP_SEL;
      end
   end

   // Control fields used by the pin logic.
   assign spiOn = spiCtrl_q[`BIT_SPI_ON];
   assign spiMaster = spiCtrl_q[`BIT_SPI_MASTER];
   assign spiPinsOd = spiCtrl_q[`BIT_SPI_PINS_OD];
   assign sciPinsOd = sciCtrl_q[`BIT_SCI_PINS_OD];
   assign databusOd = optTwo_q[`BIT_DATABUS_OD];
   assign serialPeripheralControl = spiCtrl_q;
   assign asyncSerialControlOne = sciCtrl_q;
   assign systemOptionsTwo = optTwo_q;

   // Pin levels split per port.
   assign inA = pinIn[`PIN_A +: 8];
   assign inB = pinIn[`PIN_B +: 8];
   assign inC = pinIn[`PIN_C +: 8];
   assign inD = {2'h0, pinIn[`PIN_D +: 6]};
   assign extDataIn = inC;

   // Data reads show the pin for inputs and the latch for outputs.
   assign readA = (inA & ~dirA_q) | (dataA_q & dirA_q);
   assign readB = (inB & ~dirB_q) | (dataB_q & dirB_q);
   assign readC = (inC & ~dirC_q) | (dataC_q & dirC_q);
   assign readD = (inD & ~dirD_q) | (dataD_q & dirD_q);

   // Read data selection.
   assign acc.rdData =
      (acc.rdIndex == `IDX_PORT_A_DATA) ? readA :
      (acc.rdIndex == `IDX_PORT_A_DIR) ? dirA_q :
      (acc.rdIndex == `IDX_PORT_B_DIR) ? dirB_q :
      (acc.rdIndex == `IDX_PORT_B_DATA) ? readB :
      (acc.rdIndex == `IDX_PORT_C_DATA) ? readC :
      (acc.rdIndex == `IDX_PORT_C_DIR) ? dirC_q :
      (acc.rdIndex == `IDX_PORT_D_DATA) ? readD :
      (acc.rdIndex == `IDX_PORT_D_DIR) ? dirD_q :
      (acc.rdIndex == `IDX_SPI_CTRL) ? spiCtrl_q :
      (acc.rdIndex == `IDX_SCI_CTRL_ONE) ? sciCtrl_q :
      (acc.rdIndex == `IDX_OPTIONS_TWO) ? optTwo_q :
      (acc.rdIndex == `IDX_PULLUP_SEL) ? pullSel_q : `RST_BYTE;

   // Address port: general I/O in single-chip mode, high address otherwise.
   assign wantB = modeExpanded ? `ALL_ONES : dirB_q;
   assign valB = modeExpanded ? extAddrHigh : dataB_q;

   // Data port: general I/O in single-chip mode, external data bus otherwise.
   assign wantC = modeExpanded ? {8{extDataDrive}} : dirC_q;
   assign valC = modeExpanded ? extDataOut : dataC_q;

   // Serial port receive and transmit pins follow the SCI when it uses them.
   assign wantD[0] = sciRxEnable ? 1'b0 : dirD_q[0];
   assign valD[0] = dataD_q[0];
   assign wantD[1] = sciTxEnable | dirD_q[1];
   assign valD[1] = sciTxEnable ? sciTxData : dataD_q[1];

   // SPI pins: SPI inputs are forced in, SPI outputs still need the direction bit.
   assign spiOuts = spiMaster ? `SPI_MASTER_OUTS : `SPI_SLAVE_OUTS;
   assign wantD[4:2] = spiOn ? (spiOuts & dirD_q[4:2]) : dirD_q[4:2];
   assign valD[4:2] = spiOn ? spiPinOut : dataD_q[4:2];

   // Select pin: ignored direction as slave, fault input or output as master.
   assign wantD[5] = (spiOn & ~spiMaster) ? 1'b0 : dirD_q[5];
   assign valD[5] = dataD_q[5];

   // Whole pin vectors for the output stage.
   assign wantAll = {wantD, wantC, wantB, dirA_q};
   assign valAll = {valD, valC, valB, dataA_q};
   assign odAll = {{4{spiPinsOd}}, {2{sciPinsOd}}, {8{databusOd}}, 16'h0000};

   // Registered pad drivers with per-pin open-drain conversion.
   pin_output_stage u_pins (
      .clock(clock), .rst(rst),
      .want(wantAll), .value(valAll), .openDrain(odAll),
      .pinOut(pinOut), .pinOe(pinOe)
   );

   // Pull-ups only in single-chip mode and only on pins that are inputs.
   assign pullUpEnable[7:0] = (modeExpanded | ~pullSel_q[`BIT_PULLUP_B]) ? `RST_BYTE : ~dirB_q;
   assign pullUpEnable[15:8] = (modeExpanded | ~pullSel_q[`BIT_PULLUP_C]) ? `RST_BYTE : ~dirC_q;

   // All checks run on the block clock and rest during reset.
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // Steps of a port A direction write and its effect on the pads.
   sequence s_dir_a_write;
      acc.wrEn && acc.wrIndex == `IDX_PORT_A_DIR;
   endsequence

   sequence s_pins_follow_a;
      ##2 pinOe[`PIN_A +: 8] == $past(acc.wrData, 2);
   endsequence

   // A port A direction write reaches the pad enables two edges later.
   chk_dir_a_pins: assert property (s_dir_a_write |-> s_pins_follow_a)
      else $error("Port A enables do not follow the written direction.");

   // Leaving reset, every direction bit and pad enable is clear.
   chk_dir_reset_zero: assert property ($fell(rst) |-> dirA_q == 8'h00 && dirB_q == 8'h00 &&
      dirC_q == 8'h00 && dirD_q == 8'h00 && pinOe == 30'h00000000)
      else $error("Direction or enables not clear after reset.");

   // A single-chip address port with input directions stays released.
   chk_addr_port_input: assert property (!modeExpanded && dirB_q == 8'h00 |=>
      pinOe[`PIN_B +: 8] == 8'h00)
      else $error("Address port drives in single-chip mode with inputs selected.");

   // Expanded mode drives the high address on the address port.
   chk_addr_port_drive: assert property (modeExpanded |=> pinOe[`PIN_B +: 8] == 8'hFF &&
      pinOut[`PIN_B +: 8] == $past(extAddrHigh))
      else $error("Address port does not drive the high address.");

   // A write to a removed latch is refused and leaves both latches as they were.
   chk_bus_port_unmapped: assert property (modeExpanded && busPortIdxWr |-> !acc.wrHit ##1
      ($stable(dataB_q) && $stable(dataC_q)))
      else $error("Bus port latch still mapped in expanded mode.");

   // Single-chip data port enables follow its direction register.
   chk_data_port_dir: assert property (!modeExpanded && !databusOd |=>
      pinOe[`PIN_C +: 8] == $past(dirC_q))
      else $error("Data port enables do not follow its direction.");

   // A driving external bus owns the data port pads.
   chk_data_port_bus: assert property (modeExpanded && extDataDrive && !databusOd |=>
      pinOe[`PIN_C +: 8] == 8'hFF && pinOut[`PIN_C +: 8] == $past(extDataOut))
      else $error("Data port does not carry the external data bus.");

   // Open-drain data port pins never drive high.
   chk_data_port_od: assert property ($past(databusOd) |->
      (pinOe[`PIN_C +: 8] & pinOut[`PIN_C +: 8]) == 8'h00)
      else $error("Data port drives high while open-drain.");

   // As a slave the select pin is always released.
   chk_slave_ss_input: assert property (spiOn && !spiMaster |=> !pinOe[`PIN_D + 5])
      else $error("Select pin drives while SPI is a slave.");

   // As a master the select pin follows its direction bit.
   chk_master_ss_dir: assert property (spiOn && spiMaster && !spiPinsOd |=>
      pinOe[`PIN_D + 5] == $past(dirD_q[5]))
      else $error("Select pin does not follow its direction as master.");

   // Pins that the SPI reads are never driven.
   chk_spi_inputs: assert property (spiOn |=>
      (pinOe[`PIN_D + 2 +: 3] & ~$past(spiOuts)) == 3'h0)
      else $error("SPI input pin drives.");

   // SPI output pins drive only with their direction bit set.
   chk_spi_outputs: assert property (spiOn && !spiPinsOd |=>
      pinOe[`PIN_D + 2 +: 3] == ($past(spiOuts) & $past(dirD_q[4:2])))
      else $error("SPI output pin enable wrong.");

   // Open-drain SPI pins never drive high.
   chk_spi_pins_od: assert property ($past(spiPinsOd) |->
      (pinOe[`PIN_D + 2 +: 4] & pinOut[`PIN_D + 2 +: 4]) == 4'h0)
      else $error("SPI pin drives high while open-drain.");

   // Open-drain receive and transmit pins never drive high.
   chk_sci_pins_od: assert property ($past(sciPinsOd) |->
      (pinOe[`PIN_D +: 2] & pinOut[`PIN_D +: 2]) == 2'h0)
      else $error("SCI pin drives high while open-drain.");

   // A port A data write lands in the latch.
   chk_latch_write: assert property (wrA |=> dataA_q == $past(acc.wrData))
      else $error("Port A latch not updated by a write.");

   // Port D reads show the latch on outputs and zero in the top two bits.
   chk_read_mix: assert property (acc.rdIndex == `IDX_PORT_D_DATA |->
      acc.rdData[7:6] == 2'h0 && (acc.rdData[5:0] & dirD_q[5:0]) == (dataD_q[5:0] & dirD_q[5:0]))
      else $error("Port D read does not show the latch on outputs.");

   // Expanded mode never enables a pull-up on the bus ports.
   chk_pullup_mode: assert property (modeExpanded |-> pullUpEnable == 16'h0000)
      else $error("Pull-up enabled in expanded mode.");

   // An idle external data bus releases the data port.
   chk_data_port_input: assert property (modeExpanded && !extDataDrive |=>
      pinOe[`PIN_C +: 8] == 8'h00)
      else $error("Data port drives while the external bus is idle.");
endmodule // parallel_port_direction_control

// ===== tb/pin_circuit_model.sv
/*
 Outside circuitry on the port pads.
 Assumes pad enable high means the block drives the pin.
*/
`timescale 1ns/10ps
module pin_circuit_model (
   // Block side.
   input wire logic [29:0] pinOut,
   input wire logic [29:0] pinOe,
   input wire logic [15:0] pullUpEnable,
   // Level the outside world puts on released pins.
   input wire logic [29:0] extLevel,
   // Resolved pad level.
   output logic [29:0] pinIn
);
   // A driven pin shows its value, a released one the pull-up or outside level.
   assign pinIn = (pinOe & pinOut) | (~pinOe & ({6'h00, pullUpEnable, 8'h00} | extLevel));
endmodule // pin_circuit_model

// ===== tb/parallel_port_direction_control_test.sv
/*
 Self-checking bench for the parallel port block.
 Assumes the pin circuit model on the pads and acts as the AXI4-Lite master.
*/
`timescale 1ns/10ps
module parallel_port_direction_control_test;
   logic clock = 1'h0, rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0, modeExpanded = 1'h0, extDataDrive = 1'h0;
   logic sciTxEnable = 1'h0, sciTxData = 1'h0, sciRxEnable = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [3:0] wstrb = 4'hF;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, extAddrHigh = 8'h00, extDataOut = 8'h00;
   logic [7:0] extDataIn, serialPeripheralControl, asyncSerialControlOne, systemOptionsTwo;
   logic [2:0] spiPinOut = 3'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [29:0] pinIn, pinOut, pinOe, extLevel = 30'h2A5A5A5A;
   logic [15:0] pullUpEnable;
   int mismatches = 0, checked = 0, cycles = 0;
   parallel_port_direction_control i_parallel_port_direction_control (.clock, .rst,
      .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
      .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .modeExpanded,
      .extAddrHigh, .extDataOut, .extDataDrive, .extDataIn, .spiPinOut, .sciTxEnable,
      .sciTxData, .sciRxEnable, .serialPeripheralControl, .asyncSerialControlOne,
      .systemOptionsTwo, .pinIn, .pinOut, .pinOe, .pullUpEnable);
   pin_circuit_model i_pin_circuit_model (.pinOut, .pinOe, .pullUpEnable, .extLevel, .pinIn);
   // Clock, and a cycle ceiling that cuts a hang short.
   always #4 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         summarize;
      end
   end
   // Compares one value and reports a mismatch at once.
   task automatic ck(input logic [33:0] got, input logic [33:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // One register write; address and data are released each when taken.
   task automatic wr(input logic [7:0] a, d, input logic [1:0] r = 2'h0);
      logic sa, sw, sb;
      logic [1:0] sr;
      @(posedge clock);
      {awvalid, wvalid, bready} <= 3'h7;
      awaddr <= a;
      wdata <= {24'h0, d};
      do begin
         @(negedge clock);
         {sa, sw, sb, sr} = {awready, wready, bvalid, bresp};
         @(posedge clock);
         if (sa) awvalid <= 1'h0;
         if (sw) wvalid <= 1'h0;
         if (sb) bready <= 1'h0;
      end while (!sb);
      ck(sr, r);
   endtask
   // One register read, checking response code and data together.
   task automatic rd(input logic [7:0] a, d, input logic [1:0] r = 2'h0);
      logic sa, sv;
      logic [33:0] s;
      @(posedge clock);
      {arvalid, rready} <= 2'h3;
      araddr <= a;
      do begin
         @(negedge clock);
         {sa, sv, s} = {arready, rvalid, rresp, rdata};
         @(posedge clock);
         if (sa) arvalid <= 1'h0;
         if (sv) rready <= 1'h0;
      end while (!sv);
      ck(s, {r, 24'h0, d});
   endtask
   // Lets a register or input change reach the pads.
   task automatic st;
      repeat (2) @(posedge clock);
      @(negedge clock);
   endtask
   // Reset values, an unmapped place and bits that read zero.
   task automatic t_reset;
      ck(pinOe, 30'h0);
      ck(pullUpEnable, 16'h0);
      rd(8'h04, 8'h00);
      rd(8'h08, 8'h00);
      rd(8'h1C, 8'h00);
      rd(8'h24, 8'h00);
      rd(8'h20, 8'h2A);
      wstrb <= 4'hE;
      wr(8'h04, 8'hFF);
      wstrb <= 4'hF;
      rd(8'h04, 8'h00);
      rd(8'h0C, 8'h00, 2'h3);
      wr(8'hE0, 8'hFF);
      rd(8'hE0, 8'hDF);
      wr(8'hE0, 8'h00);
   endtask
   // Mixed directions on one port: drive and read-back per pin.
   task automatic t_dir;
      wr(8'h04, 8'hF0);
      wr(8'h00, 8'hC3);
      st;
      ck(pinOe[7:0], 8'hF0);
      ck(pinOut[7:4], 4'hC);
      rd(8'h00, 8'hCA);
      wr(8'h04, 8'h0F);
      st;
      ck(pinOe[7:0], 8'h0F);
      rd(8'h00, 8'h53);
   endtask
   // Expanded mode hands ports B and C to the external bus.
   task automatic t_mode;
      @(posedge clock);
      {modeExpanded, extDataDrive, extAddrHigh, extDataOut} <= {2'h3, 16'h816E};
      st;
      ck({pinOe[23:8], pinOut[23:8]}, 32'hFFFF6E81);
      wr(8'h10, 8'h11, 2'h3);
      rd(8'h18, 8'h00, 2'h3);
      @(posedge clock);
      extDataDrive <= 1'h0;
      st;
      ck({pinOe[23:16], extDataIn}, 16'h005A);
      @(posedge clock);
      modeExpanded <= 1'h0;
      wr(8'hF4, 8'h03);
      st;
      ck({pinOe[15:8], pullUpEnable}, 24'h00FFFF);
   endtask
   // Data port open-drain option.
   task automatic t_drain;
      wr(8'h1C, 8'hFF);
      wr(8'h18, 8'hF0);
      wr(8'hE0, 8'h40);
      st;
      ck({pinOe[23:16], pinOut[23:16]}, 16'h0F00);
      ck(systemOptionsTwo, 8'h40);
      wr(8'hE0, 8'h00);
      st;
      ck({pinOe[23:16], pinOut[23:16]}, 16'hFFF0);
   endtask
   // Serial peripheral takeover of the serial port, master and slave.
   task automatic t_spi;
      @(posedge clock);
      spiPinOut <= 3'h7;
      wr(8'h24, 8'h3F);
      wr(8'h20, 8'h20);
      wr(8'hA0, 8'h50);
      st;
      ck({pinOe[29:24], pinOut[29:24] & pinOe[29:24]}, 12'hEF8);
      wr(8'hA0, 8'h40);
      st;
      ck({pinOe[29:24], pinOut[26]}, 7'h0F);
      wr(8'h24, 8'h1B);
      st;
      ck(pinOe[29:24], 6'h03);
      wr(8'hA0, 8'h50);
      st;
      ck(pinOe[29:24], 6'h1B);
      @(posedge clock);
      spiPinOut <= 3'h0;
      wr(8'h24, 8'h3F);
      wr(8'hA0, 8'h70);
      st;
      ck({pinOe[29:24], serialPeripheralControl}, 14'h1B70);
      wr(8'hA0, 8'h00);
   endtask
   // Serial interface open-drain option on the transmit and receive pins.
   task automatic t_sci;
      wr(8'hB0, 8'h40);
      @(posedge clock);
      {sciTxEnable, sciTxData, sciRxEnable} <= 3'h7;
      st;
      ck(pinOe[25:24], 2'h0);
      ck(asyncSerialControlOne, 8'h40);
      @(posedge clock);
      sciTxData <= 1'h0;
      st;
      ck({pinOe[25:24], pinOut[25]}, 3'h4);
      wr(8'hB0, 8'h00);
      @(posedge clock);
      sciTxData <= 1'h1;
      st;
      ck({pinOe[25:24], pinOut[25]}, 3'h5);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic summarize;
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Reset for 12 cycles, then every scenario in turn.
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'h0;
      t_reset;
      t_dir;
      t_mode;
      t_drain;
      t_spi;
      t_sci;
      summarize;
   end
endmodule // parallel_port_direction_control_test
